// [core/cfg_header.sv]
// Configuration header front: identification words and command register
`timescale 1ns/1ps
module cfg_header #(
  // Arbitrary identification values
  parameter logic [15:0] MAKER_ID = 16'h1a2b,
  parameter logic [15:0] FUNCTION_ID = 16'h3c4d
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Configuration access
  input wire cfg_header_pkg::cfg_req_t cfg_req,
  output cfg_header_pkg::cfg_rsp_t cfg_rsp,
  // Function-side events and requests
  input wire logic func_irq,
  input wire logic addr_parity_err,
  input wire logic data_parity_err,
  input wire logic master_active,
  input wire logic mem_cycle_hit,
  input wire logic master_req,
  input wire logic master_write_req,
  input wire logic line_write_ok,
  // Gated results toward the bus engine
  output logic mem_claim_r,
  output logic initiator_grant_r,
  output logic write_use_mwi_r,
  // Bus pins
  input wire logic parity_error_pin_in_n,
  output logic parity_error_pin_out_n,
  output logic parity_error_pin_oe_n,
  output logic system_error_pin_out_n,
  output logic system_error_pin_oe_n,
  output logic int_pin_out_n,
  output logic int_pin_oe_n
);
  import cfg_header_pkg::*;

  // ==========================================================================
  // Decode helpers
  function automatic logic hits_dword(input cfg_req_t r, input logic [5:0] dw);
    hits_dword = r.valid && (r.addr[7:2] == dw);
  endfunction : hits_dword

  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic master_parity_r;
  logic perr_seen_n;
  logic flag_clear;
  logic flag_set;
  logic irq_level_r;
  ctrl_bits_t ctrl;

  // One driver for the whole carrier; field order follows the struct
  assign ctrl = {ctrl_r[INT_DISABLE_BIT], ctrl_r[SYS_ERR_DRIVE_BIT], ctrl_r[PARITY_RESP_BIT],
                 ctrl_r[WRITE_INV_BIT], ctrl_r[INITIATOR_BIT], ctrl_r[MEM_SPACE_BIT]};

  // ==========================================================================
  // Command register write; read-only bits are masked, not refused
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (hits_dword(cfg_req, CTRL_DWORD) && cfg_req.write) begin
      if (cfg_req.byte_en[0]) begin
        ctrl_nxt[7:0] = cfg_req.wdata[7:0] & CTRL_WRITE_MASK[7:0];
      end
      if (cfg_req.byte_en[1]) begin
        ctrl_nxt[15:8] = cfg_req.wdata[15:8] & CTRL_WRITE_MASK[15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt & CTRL_WRITE_MASK;
    end
  end

  // ==========================================================================
  // Master data parity flag; set wins over a write-one clear
  assign flag_set = master_active && !perr_seen_n && ctrl.parity_resp;
  assign flag_clear = hits_dword(cfg_req, CTRL_DWORD) && cfg_req.write &&
                      cfg_req.byte_en[3] && cfg_req.wdata[16 + MASTER_PARITY_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      master_parity_r <= 1'b0;
    end else if (flag_set) begin
      master_parity_r <= 1'b1;
    end else if (flag_clear) begin
      master_parity_r <= 1'b0;
    end
  end

  // Raw interrupt level kept for status; the disable does not affect it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_level_r <= 1'b0;
    end else begin
      irq_level_r <= func_irq;
    end
  end

  // ==========================================================================
  // Read response; unmapped dwords read zero and still complete
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.ack <= cfg_req.valid;
      cfg_rsp.rdata <= '0;
      if (cfg_req.valid && !cfg_req.write) begin
        case (cfg_req.addr[7:2])
          ID_DWORD: cfg_rsp.rdata <= {FUNCTION_ID, MAKER_ID};
          CTRL_DWORD: begin
            cfg_rsp.rdata[15:0] <= ctrl_r & CTRL_WRITE_MASK;
            cfg_rsp.rdata[16 + MASTER_PARITY_BIT] <= master_parity_r;
            cfg_rsp.rdata[16 + INT_STATUS_BIT] <= irq_level_r;
          end
          default: cfg_rsp.rdata <= '0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Gating of the bus engine
  // Memory claim gates only memory cycles; configuration requests
  // are acknowledged whether or not software has enabled it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_claim_r <= 1'b0;
    end else begin
      mem_claim_r <= mem_cycle_hit && ctrl.mem_space;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      initiator_grant_r <= 1'b0;
    end else begin
      initiator_grant_r <= master_req && ctrl.initiator;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_use_mwi_r <= 1'b0;
    end else begin
      write_use_mwi_r <= master_req && ctrl.initiator && master_write_req &&
                         line_write_ok && ctrl.write_inv;
    end
  end

  // ==========================================================================
  // Pins
  pin_sync #(
    .RESET_LEVEL(1'b1)
  ) u_perr_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin(parity_error_pin_in_n),
    .level(perr_seen_n)
  );

  od_pin_drive u_serr_drv (
    .clk(clk),
    .reset_n(reset_n),
    .enable(ctrl.sys_err_drive),
    .assert_req(addr_parity_err),
    .pin_out_n(system_error_pin_out_n),
    .pin_oe_n(system_error_pin_oe_n)
  );

  od_pin_drive u_perr_drv (
    .clk(clk),
    .reset_n(reset_n),
    .enable(ctrl.parity_resp),
    .assert_req(data_parity_err),
    .pin_out_n(parity_error_pin_out_n),
    .pin_oe_n(parity_error_pin_oe_n)
  );

  od_pin_drive u_int_drv (
    .clk(clk),
    .reset_n(reset_n),
    .enable(!ctrl.int_disable),
    .assert_req(func_irq),
    .pin_out_n(int_pin_out_n),
    .pin_oe_n(int_pin_oe_n)
  );

  // ==========================================================================
  // Checks
  sequence s_id_read;
    cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == ID_DWORD;
  endsequence

  sequence s_ctrl_write_all;
    cfg_req.valid && cfg_req.write && cfg_req.addr[7:2] == CTRL_DWORD &&
    cfg_req.byte_en[1:0] == 2'b11 && cfg_req.wdata[15:0] == 16'hffff;
  endsequence

  sequence s_ctrl_read;
    cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == CTRL_DWORD;
  endsequence

  property p_id_value;
    @(posedge clk) disable iff (!reset_n)
      s_id_read |=> cfg_rsp.ack && cfg_rsp.rdata == {FUNCTION_ID, MAKER_ID};
  endproperty
  a_id_value: assert property (p_id_value)
    else $error("Identification words read back wrong");

  property p_id_write_ignored;
    @(posedge clk) disable iff (!reset_n)
      (cfg_req.valid && cfg_req.write && cfg_req.addr[7:2] == ID_DWORD)
      ##2 s_id_read |=> cfg_rsp.rdata == {FUNCTION_ID, MAKER_ID};
  endproperty
  a_id_write_ignored: assert property (p_id_write_ignored)
    else $error("Write altered identification words");

  property p_reset_zero;
    @(posedge clk) $rose(reset_n) |-> ctrl_r == 16'h0000;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Command register not zero after reset");

  property p_hardwired;
    @(posedge clk) disable iff (!reset_n)
      s_ctrl_write_all ##1 !cfg_req.valid ##1 s_ctrl_read |=>
      cfg_rsp.ack && cfg_rsp.rdata[15:0] == 16'h0556;
  endproperty
  a_hardwired: assert property (p_hardwired)
    else $error("Hardwired command bits read nonzero or writable bits lost");

  property p_int_blocked;
    @(posedge clk) disable iff (!reset_n)
      ctrl.int_disable |=> int_pin_oe_n && int_pin_out_n;
  endproperty
  a_int_blocked: assert property (p_int_blocked)
    else $error("Interrupt driven while disabled");

  property p_int_normal;
    @(posedge clk) disable iff (!reset_n)
      (!ctrl.int_disable && func_irq) |=> !int_pin_oe_n && !int_pin_out_n;
  endproperty
  a_int_normal: assert property (p_int_normal)
    else $error("Interrupt not driven while enabled");

  property p_serr_quiet;
    @(posedge clk) disable iff (!reset_n)
      !ctrl.sys_err_drive |=> system_error_pin_oe_n;
  endproperty
  a_serr_quiet: assert property (p_serr_quiet)
    else $error("System error driven while driver disabled");

  property p_serr_fire;
    @(posedge clk) disable iff (!reset_n)
      (ctrl.sys_err_drive && addr_parity_err) |=> !system_error_pin_oe_n ##1
      (system_error_pin_oe_n || $past(addr_parity_err));
  endproperty
  a_serr_fire: assert property (p_serr_fire)
    else $error("System error not asserted for one cycle on address parity error");

  property p_perr_gate;
    @(posedge clk) disable iff (!reset_n)
      $fell(parity_error_pin_oe_n) |-> $past(ctrl.parity_resp) && $past(data_parity_err);
  endproperty
  a_perr_gate: assert property (p_perr_gate)
    else $error("Parity error pin driven without response enable");

  property p_mwi_gate;
    @(posedge clk) disable iff (!reset_n)
      write_use_mwi_r |-> $past(ctrl.write_inv) && initiator_grant_r;
  endproperty
  a_mwi_gate: assert property (p_mwi_gate)
    else $error("Write-invalidate used while disabled");

  property p_master_gate;
    @(posedge clk) disable iff (!reset_n)
      !ctrl.initiator |=> !initiator_grant_r;
  endproperty
  a_master_gate: assert property (p_master_gate)
    else $error("Master cycle granted while initiator disabled");

  property p_mem_gate;
    @(posedge clk) disable iff (!reset_n)
      mem_cycle_hit |=> mem_claim_r == $past(ctrl.mem_space);
  endproperty
  a_mem_gate: assert property (p_mem_gate)
    else $error("Memory claim does not follow memory space enable");

  property p_flag_cause;
    @(posedge clk) disable iff (!reset_n)
      $rose(master_parity_r) |-> $past(master_active) && $past(ctrl.parity_resp) &&
      !$past(perr_seen_n);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("Master parity flag set without its conditions");

  property p_flag_set;
    @(posedge clk) disable iff (!reset_n)
      (master_active && !perr_seen_n && ctrl.parity_resp) |=> master_parity_r;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Master parity flag not set or lost to a clear");

  property p_ack_next;
    @(posedge clk) disable iff (!reset_n)
      cfg_req.valid |=> cfg_rsp.ack;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("Configuration request not acknowledged next cycle");

  property p_perr_respond;
    @(posedge clk) disable iff (!reset_n)
      (ctrl.parity_resp && data_parity_err) |=>
      !parity_error_pin_oe_n && !parity_error_pin_out_n;
  endproperty
  a_perr_respond: assert property (p_perr_respond)
    else $error("Parity error pin not driven while response enabled");

  sequence s_ctrl_write_low;
    cfg_req.valid && cfg_req.write && cfg_req.addr[7:2] == CTRL_DWORD && cfg_req.byte_en[0];
  endsequence

  property p_low_byte_lands;
    @(posedge clk) disable iff (!reset_n)
      s_ctrl_write_low |=> ctrl_r[7:0] == ($past(cfg_req.wdata[7:0]) & CTRL_WRITE_MASK[7:0]);
  endproperty
  a_low_byte_lands: assert property (p_low_byte_lands)
    else $error("Command low byte write did not land");

endmodule : cfg_header

// [core/cfg_header_pkg.sv]
// Constants and carrier types for the function configuration header
package cfg_header_pkg;

  // ==========================================================================
  // Register offsets (byte addresses in configuration space)
  localparam logic [7:0] MAKER_ID_OFS = 8'h00;
  localparam logic [7:0] FUNCTION_ID_OFS = 8'h02;
  localparam logic [7:0] BUS_CTRL_OFS = 8'h04;
  localparam logic [7:0] BUS_STATUS_OFS = 8'h06;

  // Dword indices used by the access decoder
  localparam logic [5:0] ID_DWORD = 6'h00;
  localparam logic [5:0] CTRL_DWORD = 6'h01;

  // ==========================================================================
  // Command register fields
  localparam int PORT_SPACE_BIT = 0;
  localparam int MEM_SPACE_BIT = 1;
  localparam int INITIATOR_BIT = 2;
  localparam int SPECIAL_CYCLE_BIT = 3;
  localparam int WRITE_INV_BIT = 4;
  localparam int PALETTE_SNOOP_BIT = 5;
  localparam int PARITY_RESP_BIT = 6;
  localparam int STEPPING_BIT = 7;
  localparam int SYS_ERR_DRIVE_BIT = 8;
  localparam int BACK_TO_BACK_BIT = 9;
  localparam int INT_DISABLE_BIT = 10;
  localparam int RSVD_LSB = 11;
  localparam int RSVD_MSB = 15;

  // Only these bits are stored; all others are hardwired to zero
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h0556;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ==========================================================================
  // Status half-word fields
  localparam int INT_STATUS_BIT = 3;
  localparam int MASTER_PARITY_BIT = 8;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic int_disable;
    logic sys_err_drive;
    logic parity_resp;
    logic write_inv;
    logic initiator;
    logic mem_space;
  } ctrl_bits_t;

endpackage : cfg_header_pkg

// [core/od_pin_drive.sv]
// Registered open-drain driver for an active-low bus signal
`timescale 1ns/1ps
module od_pin_drive (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic enable,
  input wire logic assert_req,
  // Pin
  output logic pin_out_n,
  output logic pin_oe_n
);

  // ==========================================================================
  // Drives low only when enabled; otherwise the pin floats to its pull-up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_n <= 1'b1;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out_n <= ~(enable & assert_req);
      pin_oe_n <= ~(enable & assert_req);
    end
  end

endmodule : od_pin_drive

// [core/pin_sync.sv]
// Three-stage synchroniser with agreement filter for an outside pin
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);
  import cfg_header_pkg::*;

  logic [SYNC_STAGES-1:0] stage_r;

  // ==========================================================================
  // Shift chain; stage 0 is read only by stage 1
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_r <= {SYNC_STAGES{RESET_LEVEL}};
    end else begin
      stage_r <= {stage_r[SYNC_STAGES-2:0], pin};
    end
  end

  // A change counts only once the last two stages agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level <= RESET_LEVEL;
    end else if (stage_r[1] == stage_r[2]) begin
      level <= stage_r[2];
    end
  end

endmodule : pin_sync

// [verif/bus_wire_model.sv]
// Host-side bus wires: pulled-up open-drain lines and a second parity agent
`timescale 1ns/1ps
module bus_wire_model (
  // Function drivers
  input wire logic perr_out_n,
  input wire logic perr_oe_n,
  input wire logic serr_out_n,
  input wire logic serr_oe_n,
  input wire logic int_out_n,
  input wire logic int_oe_n,
  // Another agent reporting a data parity error
  input wire logic agent_perr,
  // Resolved wire levels
  output logic perr_wire_n,
  output logic serr_wire_n,
  output logic int_wire_n
);
  // ==========================================================================
  // Released lines go to the pull-up level, never to the last driven value
  assign perr_wire_n = !((!perr_oe_n && !perr_out_n) || agent_perr);
  assign serr_wire_n = !(!serr_oe_n && !serr_out_n);
  assign int_wire_n = !(!int_oe_n && !int_out_n);
endmodule : bus_wire_model

// [verif/ohci_pci_config_header_command_tb.sv]
// Self-checking bench for the configuration header front
`timescale 1ns/1ps
module ohci_pci_config_header_command_tb;
  import cfg_header_pkg::*;
  localparam logic [15:0] MAKER = 16'h1a2b; // Arbitrary value
  localparam logic [15:0] FUNC = 16'h3c4d; // Arbitrary value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  cfg_req_t cfg_req = '0;
  cfg_rsp_t cfg_rsp;
  // Events: irq, addr par, data par, master, mem hit, mreq, mwrite, line ok
  logic [7:0] ev = 8'h00;
  logic agent_perr = 1'b0;
  logic mem_claim_r, initiator_grant_r, write_use_mwi_r;
  logic perr_o, perr_oe, serr_o, serr_oe, int_o, int_oe;
  logic perr_w, serr_w, int_w;
  integer n_errors = 0;
  integer checks_done = 0;
  logic [15:0] cmd_m = 16'h0000;
  logic flag_m = 1'b0;
  logic [31:0] rd;
  logic [7:0] adr [4] = '{8'h00, 8'h02, 8'h04, 8'h40};

  always #2 clk = ~clk;

  cfg_header #(.MAKER_ID(MAKER), .FUNCTION_ID(FUNC)) dut (
    .clk(clk), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .func_irq(ev[0]), .addr_parity_err(ev[1]), .data_parity_err(ev[2]),
    .master_active(ev[3]), .mem_cycle_hit(ev[4]), .master_req(ev[5]),
    .master_write_req(ev[6]), .line_write_ok(ev[7]),
    .mem_claim_r(mem_claim_r), .initiator_grant_r(initiator_grant_r),
    .write_use_mwi_r(write_use_mwi_r), .parity_error_pin_in_n(perr_w),
    .parity_error_pin_out_n(perr_o), .parity_error_pin_oe_n(perr_oe),
    .system_error_pin_out_n(serr_o), .system_error_pin_oe_n(serr_oe),
    .int_pin_out_n(int_o), .int_pin_oe_n(int_oe));

  bus_wire_model wires (
    .perr_out_n(perr_o), .perr_oe_n(perr_oe), .serr_out_n(serr_o),
    .serr_oe_n(serr_oe), .int_out_n(int_o), .int_oe_n(int_oe),
    .agent_perr(agent_perr), .perr_wire_n(perr_w), .serr_wire_n(serr_w),
    .int_wire_n(int_w));

  // ==========================================================================
  // Checking and reporting
  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task results;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Model read value; status keeps only the parity flag and raw interrupt
  function logic [31:0] exp_rd(input logic [7:0] a);
    case (a[7:2])
      6'h00: exp_rd = {FUNC, MAKER};
      6'h01: exp_rd = {7'h00, flag_m, 4'h0, ev[0], 3'h0, cmd_m};
      default: exp_rd = 32'h0;
    endcase
  endfunction : exp_rd

  // ==========================================================================
  // One request, answer taken 1 ns after the edge that takes it
  task access(input logic wr, input logic [7:0] a, input logic [3:0] be,
              input logic [31:0] wd);
    @(posedge clk);
    cfg_req <= '{1'b1, wr, a, be, wd};
    @(posedge clk);
    cfg_req.valid <= 1'b0;
    #1;
    rd = cfg_rsp.rdata;
    check({31'h0, cfg_rsp.ack}, 32'h1, "ack");
    if (wr) begin
      check(rd, 32'h0, "rdata on write");
    end
  endtask : access

  // Write, update the model, read back
  task wr_rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    access(1'b1, a, be, wd);
    if (a[7:2] == 6'h01) begin
      // Only bits 10, 8, 6, 4, 2, 1 hold a value
      if (be[0]) cmd_m[7:0] = wd[7:0] & 8'h56;
      if (be[1]) cmd_m[15:8] = wd[15:8] & 8'h05;
      if (be[3] && wd[24]) flag_m = 1'b0;
    end
    access(1'b0, a, 4'h0, 32'h0);
    check(rd, exp_rd(a), "read back");
  endtask : wr_rd

  // Random function events, outputs checked one cycle later
  task step;
    logic [7:0] pv;
    logic [8:0] ex;
    pv = ev;
    @(posedge clk);
    ev <= 8'($urandom) & 8'hf7;
    #1;
    ex[8] = pv[4] & cmd_m[1];
    ex[7] = pv[5] & cmd_m[2];
    ex[6] = pv[5] & cmd_m[2] & pv[6] & pv[7] & cmd_m[4];
    ex[5:4] = {2{!(pv[1] & cmd_m[8])}};
    ex[3:2] = {2{!(pv[2] & cmd_m[6])}};
    ex[1:0] = {2{!(pv[0] & !cmd_m[10])}};
    check({23'h0, mem_claim_r, initiator_grant_r, write_use_mwi_r, serr_o, serr_oe,
           perr_o, perr_oe, int_o, int_oe}, {23'h0, ex}, "gated outputs");
    check({30'h0, serr_w, int_w}, {30'h0, ex[4], ex[0]}, "released wire levels");
  endtask : step

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(9));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    access(1'b0, 8'h04, 4'h0, 32'h0);
    check(rd, 32'h0, "command after reset");
    wr_rd(8'h04, 4'h3, 32'h0000_0002);
    repeat (4) step;
    wr_rd(8'h04, 4'h3, 32'hffff_ffff);
    repeat (6) step;
    for (int i = 0; i < 24; i++) begin
      wr_rd(adr[i % 4], 4'($urandom), $urandom);
      repeat (3) step;
    end
    // Parity flag needs both master ownership and parity response enabled
    for (int k = 0; k < 3; k++) begin
      wr_rd(8'h04, 4'h3, (k == 1) ? 32'h0 : 32'h0040);
      @(posedge clk);
      ev <= (k == 2) ? 8'h00 : 8'h08;
      agent_perr <= 1'b1;
      repeat (4) @(posedge clk);
      agent_perr <= 1'b0;
      repeat (6) @(posedge clk);
      ev <= 8'h00;
      flag_m = (k == 0);
      access(1'b0, 8'h04, 4'h0, 32'h0);
      check(rd, exp_rd(8'h04), "parity flag");
      wr_rd(8'h04, 4'h8, 32'h0100_0000);
    end
    // Reset in mid-run clears the command register
    wr_rd(8'h04, 4'h3, 32'h0556);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    cmd_m = 16'h0000;
    access(1'b0, 8'h04, 4'h0, 32'h0);
    check(rd, exp_rd(8'h04), "command after second reset");
    results;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    results;
  end
endmodule : ohci_pci_config_header_command_tb
